//--- inc/pfc_pkg.sv
// Purpose: Shared constants and types of the panel frequency counter
// Assumes: 100 MHz core clock
// Notes:   Times held in ms, cycle counts derived from the clock rate
package pfc_pkg;

	// =========================================================
	// Clock and timing
	localparam longint CLK_HZ      = 100_000_000;
	localparam longint MS_PER_S    = 1000;
	localparam longint TYP1_MS     = 1000;
	localparam longint TYP2_MS     = 1000;
	localparam longint TYP3_MS     = 500;
	localparam longint TYP4_MS     = 500;
	localparam longint MAX1_MS     = 3000;
	localparam longint MAX2_MS     = 2000;
	localparam longint MAX3_MS     = 1000;
	localparam longint MAX4_MS     = 1000;
	localparam longint DEBOUNCE_MS = 10;
	localparam int unsigned TYP1_CYC = int'(TYP1_MS * CLK_HZ / MS_PER_S);
	localparam int unsigned TYP2_CYC = int'(TYP2_MS * CLK_HZ / MS_PER_S);
	localparam int unsigned TYP3_CYC = int'(TYP3_MS * CLK_HZ / MS_PER_S);
	localparam int unsigned TYP4_CYC = int'(TYP4_MS * CLK_HZ / MS_PER_S);
	localparam int unsigned MAX1_CYC = int'(MAX1_MS * CLK_HZ / MS_PER_S);
	localparam int unsigned MAX2_CYC = int'(MAX2_MS * CLK_HZ / MS_PER_S);
	localparam int unsigned MAX3_CYC = int'(MAX3_MS * CLK_HZ / MS_PER_S);
	localparam int unsigned MAX4_CYC = int'(MAX4_MS * CLK_HZ / MS_PER_S);
	localparam int unsigned DEB_CYC  = int'(DEBOUNCE_MS * CLK_HZ / MS_PER_S);

	// =========================================================
	// Widths
	localparam int T_W   = 30;
	localparam int N_W   = 20;
	localparam int K_W   = 34;
	localparam int Q_W   = N_W + K_W;
	localparam int D_W   = T_W + 2;
	localparam int C_W   = 6;
	localparam int BIN_W = 14;
	localparam int BCD_W = 16;
	localparam int R_W   = 2;
	localparam int DB_W  = 24;

	// =========================================================
	// Scale: count times this over cycles gives display units
	localparam logic [K_W-1:0] SCALE_TBL [4] = '{
		K_W'(CLK_HZ * 100), K_W'(CLK_HZ * 10), K_W'(CLK_HZ), K_W'(CLK_HZ / 10)};
	// Bit k set: point right of digit k (digit 0 rightmost)
	localparam logic [3:0] POINT_TBL [4] = '{4'h4, 4'h2, 4'h0, 4'h4};
	localparam logic [BIN_W-1:0] LIM_POS = 14'h270F;
	localparam logic [BIN_W-1:0] LIM_NEG = 14'h03E7;
	localparam logic [C_W-1:0]   DIV_LAST = 6'(Q_W - 1);

	// =========================================================
	// Pin positions and idle levels
	localparam int PIN_A    = 0;
	localparam int PIN_B    = 1;
	localparam int PIN_RNG  = 2;
	localparam int PIN_HOLD = 3;
	localparam int PIN_QUAD = 4;
	localparam int NPIN     = 5;
	localparam logic [NPIN-1:0] PIN_IDLE = 5'h04;

	// =========================================================
	// Types
	typedef enum logic [3:0] {
		ST_ARM  = 4'h1,
		ST_GATE = 4'h2,
		ST_DIV  = 4'h4,
		ST_SHOW = 4'h8
	} pfc_state_t;

	typedef struct packed {
		logic             minus;
		logic [3:0]       point;
		logic [BCD_W-1:0] bcd;
	} pfc_disp_t;

endpackage

//--- core/pfc_core.sv
// Purpose: Frequency measurement core of a four-range panel counter
// Assumes: 100 MHz clock, pins asynchronous to it
// Notes:   Reciprocal gate: edges over cycles, scaled by long division
//
// Contract
// - Each range contact closure steps to the next of four ranges, wrapping.
// - Range one: 0.01 Hz resolution, 1.00-99.99 Hz, ~1 s, at most 3 s.
// - Range two: 0.1 Hz resolution, 1.6-999.9 Hz, ~1 s, at most 2 s.
// - Range three: 1 Hz resolution, 4-9999 Hz, ~0.5 s, at most 1 s.
// - Range four: 0.01 kHz resolution, to 35.00 kHz, ~0.5 s, at most 1 s.
// - Hold input freezes the shown value; measuring carries on.
// - Reverse direction shows the frequency negative.
// - Shown value clipped to -999..+9999, minus sign only when negative.
// - Decimal point placed by the selected range.
// - Pulse counting to 35 kHz; quadrature x4 decoding to 8.75 kHz.
`timescale 1ns/100ps

module pfc_core #(
	parameter int unsigned P_TYP [4] = '{pfc_pkg::TYP1_CYC, pfc_pkg::TYP2_CYC,
	                                     pfc_pkg::TYP3_CYC, pfc_pkg::TYP4_CYC},
	parameter int unsigned P_MAX [4] = '{pfc_pkg::MAX1_CYC, pfc_pkg::MAX2_CYC,
	                                     pfc_pkg::MAX3_CYC, pfc_pkg::MAX4_CYC},
	parameter int unsigned P_DEB     = pfc_pkg::DEB_CYC
) (
	input  wire logic                 i_clock,     // Core clock
	input  wire logic                 i_rst,       // Async reset, high
	input  wire logic                 i_chan_a,    // Channel A pin
	input  wire logic                 i_chan_b,    // Channel B or direction pin
	input  wire logic                 i_range_n,   // Range contact, low closed
	input  wire logic                 i_hold,      // Display hold, high
	input  wire logic                 i_quad_mode, // High: quadrature x4
	output pfc_pkg::pfc_disp_t        o_display,   // Sign, point, BCD digits
	output logic [pfc_pkg::R_W-1:0]   o_range,     // Range prompt, 0..3
	output logic                      o_fresh      // Display updated pulse
);

	// =========================================================
	// Pin synchronisers
	logic [pfc_pkg::NPIN-1:0] pin_raw;
	logic [pfc_pkg::NPIN-1:0] s1_reg;
	logic [pfc_pkg::NPIN-1:0] s2_reg;
	logic [pfc_pkg::NPIN-1:0] s3_reg;
	logic [pfc_pkg::NPIN-1:0] pin_reg;
	logic [pfc_pkg::NPIN-1:0] prev_reg;
	logic [pfc_pkg::NPIN-1:0] agree;

	assign pin_raw = {i_quad_mode, i_hold, i_range_n, i_chan_b, i_chan_a};
	assign agree   = ~(s2_reg ^ s3_reg);

	// Three stages, level taken once stages two and three agree
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			s1_reg   <= pfc_pkg::PIN_IDLE;
			s2_reg   <= pfc_pkg::PIN_IDLE;
			s3_reg   <= pfc_pkg::PIN_IDLE;
			pin_reg  <= pfc_pkg::PIN_IDLE;
			prev_reg <= pfc_pkg::PIN_IDLE;
		end else begin
			s1_reg   <= pin_raw;
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			pin_reg  <= (s3_reg & agree) | (pin_reg & ~agree);
			prev_reg <= pin_reg;
		end
	end

	// =========================================================
	// Edge qualification
	logic a_now;
	logic b_now;
	logic a_old;
	logic b_old;
	logic quad;
	logic cnt_evt;
	logic cnt_rev;

	assign a_now = pin_reg[pfc_pkg::PIN_A];
	assign b_now = pin_reg[pfc_pkg::PIN_B];
	assign a_old = prev_reg[pfc_pkg::PIN_A];
	assign b_old = prev_reg[pfc_pkg::PIN_B];
	assign quad  = pin_reg[pfc_pkg::PIN_QUAD];

	// Pulse: rising A, B is direction; quad: one channel changed, A leads fwd
	always_comb begin
		if (quad) begin
			cnt_evt = (a_now ^ a_old) ^ (b_now ^ b_old);
			cnt_rev = ~(a_now ^ b_old);
		end else begin
			cnt_evt = a_now & ~a_old;
			cnt_rev = b_now;
		end
	end

	// =========================================================
	// Range contact debounce and stepping
	logic [pfc_pkg::DB_W-1:0] deb_reg;
	logic                     btn_reg;
	logic [pfc_pkg::R_W-1:0]  range_reg;
	logic                     press;
	logic                     rng_pin;

	assign rng_pin = pin_reg[pfc_pkg::PIN_RNG];
	assign press   = btn_reg & ~rng_pin & (deb_reg == pfc_pkg::DB_W'(P_DEB - 1));

	// Contact must stay changed for the debounce time
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			deb_reg <= '0;
			btn_reg <= 1'b1;
		end else if (rng_pin == btn_reg) begin
			deb_reg <= '0;
		end else if (deb_reg == pfc_pkg::DB_W'(P_DEB - 1)) begin
			deb_reg <= '0;
			btn_reg <= rng_pin;
		end else begin
			deb_reg <= deb_reg + 1'b1;
		end
	end

	// Next range on each closure, four wraps to one
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			range_reg <= '0;
		end else if (press) begin
			range_reg <= range_reg + 1'b1;
		end
	end

	// =========================================================
	// Gate and divider
	pfc_pkg::pfc_state_t       st_reg;
	logic [pfc_pkg::T_W-1:0]   t_reg;
	logic [pfc_pkg::N_W-1:0]   n_reg;
	logic                      rev_reg;
	logic [pfc_pkg::Q_W-1:0]   num_reg;
	logic [pfc_pkg::D_W:0]     rem_reg;
	logic [pfc_pkg::D_W-1:0]   den_reg;
	logic [pfc_pkg::C_W-1:0]   cnt_reg;
	logic [pfc_pkg::T_W-1:0]   typ_lim;
	logic [pfc_pkg::T_W-1:0]   max_lim;
	logic [pfc_pkg::N_W-1:0]   n_inc;
	logic [pfc_pkg::D_W:0]     rem_sh;
	logic                      fits;

	assign typ_lim = pfc_pkg::T_W'(P_TYP[range_reg] - 1);
	assign max_lim = pfc_pkg::T_W'(P_MAX[range_reg] - 1);
	assign n_inc   = n_reg + 1'b1;
	assign rem_sh  = {rem_reg[pfc_pkg::D_W-1:0], num_reg[pfc_pkg::Q_W-1]};
	assign fits    = rem_sh >= {1'b0, den_reg};

	// Gate opens on an edge, closes on the first edge past typical time
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			st_reg  <= pfc_pkg::ST_ARM;
			t_reg   <= '0;
			n_reg   <= '0;
			rev_reg <= 1'b0;
			num_reg <= '0;
			rem_reg <= '0;
			den_reg <= '0;
			cnt_reg <= '0;
		end else if (press) begin
			st_reg <= pfc_pkg::ST_ARM;
			t_reg  <= '0;
		end else begin
			case (st_reg)
				pfc_pkg::ST_ARM: begin
					t_reg <= t_reg + 1'b1;
					if (cnt_evt) begin
						st_reg  <= pfc_pkg::ST_GATE;
						t_reg   <= '0;
						n_reg   <= '0;
						rev_reg <= cnt_rev;
					end else if (t_reg >= max_lim) begin
						st_reg  <= pfc_pkg::ST_SHOW; // Below range: shows zero
						num_reg <= '0;
					end
				end
				pfc_pkg::ST_GATE: begin
					t_reg <= t_reg + 1'b1;
					if (cnt_evt) begin
						n_reg   <= n_inc;
						rev_reg <= cnt_rev;
					end
					if (cnt_evt && t_reg >= typ_lim) begin
						st_reg  <= pfc_pkg::ST_DIV;
						num_reg <= n_inc * pfc_pkg::SCALE_TBL[range_reg];
						den_reg <= quad ? {t_reg + 1'b1, 2'b00}
						                : {2'b00, t_reg + 1'b1};
						rem_reg <= '0;
						cnt_reg <= '0;
					end else if (t_reg >= max_lim) begin
						st_reg  <= pfc_pkg::ST_SHOW;
						num_reg <= '0;
					end
				end
				pfc_pkg::ST_DIV: begin
					// One quotient bit per clock
					rem_reg <= fits ? rem_sh - {1'b0, den_reg} : rem_sh;
					num_reg <= {num_reg[pfc_pkg::Q_W-2:0], fits};
					cnt_reg <= cnt_reg + 1'b1;
					if (cnt_reg == pfc_pkg::DIV_LAST) begin
						st_reg <= pfc_pkg::ST_SHOW;
					end
				end
				pfc_pkg::ST_SHOW: begin
					st_reg <= pfc_pkg::ST_ARM;
					t_reg  <= '0;
				end
				default: begin
					st_reg <= pfc_pkg::ST_ARM;
				end
			endcase
		end
	end

	// =========================================================
	// Display formatting
	function automatic logic [pfc_pkg::BCD_W-1:0] to_bcd(
		input logic [pfc_pkg::BIN_W-1:0] v
	);
		logic [pfc_pkg::BCD_W+pfc_pkg::BIN_W-1:0] w;
		w = {{pfc_pkg::BCD_W{1'b0}}, v};
		for (int i = 0; i < pfc_pkg::BIN_W; i++) begin
			for (int d = 0; d < 4; d++) begin
				if (w[pfc_pkg::BIN_W + 4*d +: 4] > 4'h4) begin
					w[pfc_pkg::BIN_W + 4*d +: 4] = w[pfc_pkg::BIN_W + 4*d +: 4] + 4'h3;
				end
			end
			w = {w[pfc_pkg::BCD_W+pfc_pkg::BIN_W-2:0], 1'b0};
		end
		return w[pfc_pkg::BCD_W+pfc_pkg::BIN_W-1:pfc_pkg::BIN_W];
	endfunction

	logic [pfc_pkg::BIN_W-1:0] lim;
	logic [pfc_pkg::BIN_W-1:0] mag;

	// Clip to the span allowed by the sign
	always_comb begin
		lim = rev_reg ? pfc_pkg::LIM_NEG : pfc_pkg::LIM_POS;
		if (num_reg > {{(pfc_pkg::Q_W-pfc_pkg::BIN_W){1'b0}}, lim}) begin
			mag = lim;
		end else begin
			mag = num_reg[pfc_pkg::BIN_W-1:0];
		end
	end

	// Display loads after each result unless held
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_display <= '0;
			o_fresh   <= 1'b0;
		end else if (st_reg == pfc_pkg::ST_SHOW && !pin_reg[pfc_pkg::PIN_HOLD]) begin
			o_display.minus <= rev_reg && (mag != '0);
			o_display.point <= pfc_pkg::POINT_TBL[range_reg];
			o_display.bcd   <= to_bcd(mag);
			o_fresh         <= 1'b1;
		end else begin
			o_fresh <= 1'b0;
		end
	end

	// Range prompt
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_range <= '0;
		end else begin
			o_range <= range_reg;
		end
	end

endmodule

//--- test/pfc_checker.sv
// Purpose: Port checks for pfc_core
// Assumes: One clock, async active-high reset
// Notes:   Bound into every pfc_core instance
`timescale 1ns/100ps
module pfc_checker #(
	parameter int unsigned P_MAX [4] = '{pfc_pkg::MAX1_CYC, pfc_pkg::MAX2_CYC,
	                                     pfc_pkg::MAX3_CYC, pfc_pkg::MAX4_CYC}
) (
	input wire logic                   i_clock,   // Core clock
	input wire logic                   i_rst,     // Async reset
	input wire logic                   i_range_n, // Range contact
	input wire logic                   i_hold,    // Display hold
	input wire pfc_pkg::pfc_disp_t     o_display, // Shown value
	input wire logic [pfc_pkg::R_W-1:0] o_range,  // Range prompt
	input wire logic                   o_fresh    // Update pulse
);
	int unsigned gap_reg;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	// Cycles since the last update, restarted by hold or a range step
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) gap_reg <= 0;
		else if (o_fresh || i_hold || $changed(o_range)) gap_reg <= 0;
		else gap_reg <= gap_reg + 1;
	end
	fresh_pulse_a: assert property (o_fresh |=> !o_fresh [*8])
		else $error("update pulse not single");
	load_moment_a: assert property ($changed(o_display) |-> o_fresh)
		else $error("display moved without update");
	point_place_a: assert property (o_fresh |-> o_display.point == pfc_pkg::POINT_TBL[o_range])
		else $error("point wrong for range");
	digit_range_a: assert property (o_fresh |-> o_display.bcd[3:0] < 4'hA &&
		o_display.bcd[7:4] < 4'hA && o_display.bcd[11:8] < 4'hA && o_display.bcd[15:12] < 4'hA)
		else $error("digit out of range");
	neg_clip_a: assert property (o_fresh && o_display.minus |->
		o_display.bcd[15:12] == 4'h0 && o_display.bcd != 16'h0000) else $error("negative clip");
	range_step_a: assert property ($changed(o_range) |-> o_range == $past(o_range) + 2'h1)
		else $error("range did not step by one");
	range_cause_a: assert property ($changed(o_range) |-> !$past(i_range_n, 4) &&
		!$past(i_range_n, 9)) else $error("range moved without closure");
	hold_freeze_a: assert property (i_hold [*8] |=> $stable(o_display))
		else $error("display moved while held");
	update_gap_a: assert property (gap_reg <= 2 * P_MAX[o_range] + 200)
		else $error("update period too long");
endmodule
bind pfc_core pfc_checker #(.P_MAX(P_MAX)) pfc_checker_inst (.i_clock(i_clock), .i_rst(i_rst),
	.i_range_n(i_range_n), .i_hold(i_hold), .o_display(o_display), .o_range(o_range),
	.o_fresh(o_fresh));

//--- test/pfc_sensor.sv
// Purpose: Pulse or quadrature sensor model
// Assumes: Moves on the falling clock edge
// Notes:   Stopped sensor holds its channel levels
`timescale 1ns/100ps
module pfc_sensor (
	input  wire logic i_clock,  // Bench clock
	input  wire logic i_en,     // Sensor running
	input  wire logic i_quad,   // Quadrature steps
	input  wire logic i_rev,    // Reverse motion
	input  var  int   i_per,    // Cycles per pulse or step
	output logic      o_chan_a, // Channel A
	output logic      o_chan_b  // Channel B
);
	int         cnt_reg = 0;
	logic [1:0] ph_reg = 2'h0;
	// Period count and gray-code phase
	always @(negedge i_clock) begin
		if (i_en) cnt_reg <= (cnt_reg >= i_per - 1) ? 0 : cnt_reg + 1;
		if (i_en && i_quad && cnt_reg == 0) ph_reg <= i_rev ? ph_reg - 2'h1 : ph_reg + 2'h1;
	end
	// One channel moves per step, A leads forward; pulse B is direction
	assign o_chan_a = i_quad ? ph_reg[1] ^ ph_reg[0] : (cnt_reg < i_per / 2);
	assign o_chan_b = i_quad ? ph_reg[1] : i_rev;
endmodule

//--- test/pfc_core_bench.sv
// Purpose: Self-checking bench of pfc_core
// Assumes: Short gates, 33 kHz pulses, 8 kHz quadrature
// Notes:   Shown values allow two counts of gate jitter
`timescale 1ns/100ps
module pfc_core_bench;
	localparam int unsigned TB_TYP [4] = '{1000, 1000, 1000, 1000};
	localparam int unsigned TB_MAX [4] = '{4000, 4000, 4000, 4000};
	localparam logic [3:0]  PT [4]     = '{4'h4, 4'h2, 4'h0, 4'h4};
	localparam int          MAG [4]    = '{9999, 9999, 9999, 3333};
	logic                    i_clock = 1'b0;
	logic                    i_rst = 1'b1;
	logic                    i_range_n = 1'b1;
	logic                    i_hold = 1'b0;
	logic                    i_quad_mode = 1'b0;
	logic                    s_en = 1'b0;
	logic                    s_rev = 1'b0;
	int                      s_per = 3000;
	logic                    chan_a;
	logic                    chan_b;
	pfc_pkg::pfc_disp_t      o_display;
	logic [pfc_pkg::R_W-1:0] o_range;
	logic                    o_fresh;
	int                      failures = 0;
	int                      n_tests = 0;
	int                      cycles = 0;
	// Design and sensor
	pfc_core #(.P_TYP(TB_TYP), .P_MAX(TB_MAX), .P_DEB(8)) pfc_core_inst (.i_clock(i_clock),
		.i_rst(i_rst), .i_chan_a(chan_a), .i_chan_b(chan_b), .i_range_n(i_range_n),
		.i_hold(i_hold), .i_quad_mode(i_quad_mode), .o_display(o_display), .o_range(o_range),
		.o_fresh(o_fresh));
	pfc_sensor pfc_sensor_inst (.i_clock(i_clock), .i_en(s_en), .i_quad(i_quad_mode),
		.i_rev(s_rev), .i_per(s_per), .o_chan_a(chan_a), .o_chan_b(chan_b));
	// Clock
	initial forever #5 i_clock = ~i_clock;
	// Hang guard
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == 100000) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, cycles, 100000);
			close_out();
		end
	end
	function automatic logic [15:0] to_bcd(int v);
		return {4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
	endfunction
	task automatic check_disp(pfc_pkg::pfc_disp_t got, logic mi, logic [3:0] pt, int mag);
		logic ok;
		ok = 1'b0;
		for (int d = -2; d <= 2; d++) if (got === {mi, pt, to_bcd(mag + d)}) ok = 1'b1;
		n_tests++;
		if (!ok) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, {mi, pt, to_bcd(mag)});
		end
	endtask
	task automatic check_range(logic [1:0] got, logic [1:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wait_fresh(int n);
		int k;
		repeat (n) begin
			k = 0;
			do begin
				@(negedge i_clock);
				k++;
			end while (o_fresh !== 1'b1 && k < 30000);
			if (k >= 30000) begin
				failures++;
				$display("[FAIL] t=%0t got=%h exp=%h", $time, o_fresh, 1'b1);
			end
		end
	endtask
	task automatic press();
		i_range_n = 1'b0;
		repeat (20) @(negedge i_clock);
		i_range_n = 1'b1;
		repeat (20) @(negedge i_clock);
	endtask
	task automatic t_ranges();
		s_en = 1'b1;
		for (int r = 0; r < 4; r++) begin
			if (r > 0) press();
			wait_fresh(1);
			check_range(o_range, 2'(r));
			check_disp(o_display, 1'b0, PT[r], MAG[r]);
		end
		$display("t_ranges done");
	endtask
	task automatic t_wrap();
		press();
		check_range(o_range, 2'h0);
		repeat (3) press();
		check_range(o_range, 2'h3);
		$display("t_wrap done");
	endtask
	task automatic t_hold();
		wait_fresh(1);
		i_hold = 1'b1;
		s_rev = 1'b1;
		repeat (7000) @(negedge i_clock);
		check_disp(o_display, 1'b0, 4'h4, 3333);
		i_hold = 1'b0;
		wait_fresh(2);
		check_disp(o_display, 1'b1, 4'h4, 999);
		$display("t_hold done");
	endtask
	task automatic t_quad();
		i_quad_mode = 1'b1;
		s_rev = 1'b0;
		s_per = 3125;
		wait_fresh(2);
		check_disp(o_display, 1'b0, 4'h4, 800);
		s_rev = 1'b1;
		wait_fresh(2);
		check_disp(o_display, 1'b1, 4'h4, 800);
		$display("t_quad done");
	endtask
	task automatic t_idle();
		s_en = 1'b0;
		wait_fresh(2);
		check_disp(o_display, 1'b0, 4'h4, 0);
		$display("t_idle done");
	endtask
	task automatic close_out();
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (8) @(negedge i_clock);
		i_rst = 1'b0;
		t_ranges();
		t_wrap();
		t_hold();
		t_quad();
		t_idle();
		close_out();
	end
endmodule
